/* lstel_top.sv */
/*
 * local-bus slave channel termination, pci error logging and retry limiting.
 * assumes local requests are one-cycle pulses, the write fifo and the pci
 * master sit outside, and all inputs are synchronous to mclk.
 */
// Local design decisions: the placing of the registers and the strobed register port.
// Function
// [R1] reads and delayed writes are retried until pci finishes, then translated
// [R2] master-abort gives bus error, or normal with all ones if ack bit set
// [R3] target-abort gives bus error unless ack bit set and error enable clear
// [R4] pci retry and disconnect never reach the local bus
// [R5] posted write without room in the write fifo is retried
// [R6] burst write retried at start unless it fits; ongoing burst never retried
// [R7] other accesses are retried while a delayed or prefetched transfer waits
// [R8] burst to an i/o-space image ends with bus error
// [R9] async mode: acks; acks plus error; acks, error and halt
// [R10] burst-retry mode: only ack, only error, or only retry line
// [R11] two-line mode: ack; ack negated plus error; ack plus error
// [R12] board pull-ups bring floated lines to negated level
// [R13] posted writes end normally; aborted entry is lost, draining continues
// [R14] aborted read flushes read fifo; aborted posted write does not
// [R15] with logging on, aborted posted write is captured and status set
// [R16] logged error with channel locked suspends slave transfers until cleared
// [R17] software should set unlock whenever logging is enabled
// [R18] unlocked: master keeps running, log holds first error until cleared
// [R19] logging off: failed posted entry is dropped, next entry continues
// [R20] logging raises interrupt only if enabled; direction picks local or pci
// [R21] pci master counts retries, stopping at 128, 256, 384 or never
// [R22] at retry limit cycle is discarded; delayed ends in error, posted logged
// [R23] retry select codes: 0 is 128, 1 is 256, 2 is 384, 3 unlimited
`default_nettype none
module lstel_top
   import lstel_pkg::*;
#(
   parameter int BURST_BEATS = 4,
   parameter int FREE_W = 8
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic lb_req,
   input wire lstel_lreq_s lb_cmd,
   output logic lb_done,
   output logic [31:0] lb_rdata,
   output var lstel_pins_s lb_pins,
   input wire logic [FREE_W-1:0] wf_free,
   output logic wf_push,
   output var lstel_ent_s wf_data,
   input wire logic pw_valid,
   input wire lstel_ent_s pw_entry,
   output logic pw_pop,
   output logic rf_flush,
   output logic pm_req,
   output var lstel_ent_s pm_cyc,
   input wire logic pm_done,
   input wire lstel_res_e pm_result,
   input wire logic [31:0] pm_rdata,
   output logic irq_local,
   output logic irq_pci
);
   logic ma_normal_q, target_abort_bus_error_enable_q, log_en_q, log_status_q, unlock_q, irq_en_q, irq_dir_q;
   logic [1:0] max_retry_select_q;
   lstel_mode_e mode_q;
   logic [3:0] log_cmd_q, log_be_q;
   logic [31:0] log_addr_q, log_data_q;
   logic dly_busy_q, dly_done_q;
   lstel_ent_s dly_req_q;
   lstel_term_e dly_term_q, term_q, term_d;
   logic [31:0] dly_rdata_q;
   lstel_pst_e pst_q;
   logic src_q;
   logic [8:0] rcnt_q, lim;
   logic suspend, match, ongoing, push_d, latch_d;
   logic lim_hit, fin, failed, log_fire, fin_dly;
   lstel_term_e fin_term;
   logic [31:0] rdata_d;

   function automatic lstel_pins_s pins_for(lstel_mode_e m, lstel_term_e t);
      lstel_pins_s p;
      logic [3:0] a, n;
      a = 4'h0;
      n = 4'h0;
      unique case (m)
         M_BURST_RETRY: begin
            if (t == T_NORMAL) a = L_ACK1; // [R10]
            if (t == T_BERR) a = L_ERR;
            if (t == T_RETRY) a = L_HALT;
         end
         M_TWO_LINE: begin
            if (t == T_NORMAL) a = L_ACK1; // [R11]
            if (t == T_BERR) begin
               a = L_ERR;
               n = L_ACK1;
            end
            if (t == T_RETRY) a = L_ACK1 | L_ERR;
         end
         default: begin
            if (t == T_NORMAL) a = L_ACK0 | L_ACK1; // [R9]
            if (t == T_BERR) a = L_ACK0 | L_ACK1 | L_ERR;
            if (t == T_RETRY) a = L_ACK0 | L_ACK1 | L_ERR | L_HALT;
         end
      endcase
      p.o = ~a;
      p.oe_n = ~(a | n);
      return p;
   endfunction

   // local attempt decode
   assign suspend = log_status_q && !unlock_q;
   assign match = dly_done_q && lb_cmd.ent.addr == dly_req_q.addr
                  && lb_cmd.ent.write == dly_req_q.write;
   assign ongoing = lb_cmd.burst && lb_cmd.ent.write && !lb_cmd.first;

   always_comb begin
      term_d = T_NONE;
      push_d = 1'b0;
      latch_d = 1'b0;
      if (lb_req) begin
         if (ongoing) begin
            term_d = T_NORMAL; // [R6]
            push_d = 1'b1;
         end else if (suspend) begin
            term_d = T_RETRY; // [R16]
         end else if (lb_cmd.burst && lb_cmd.io_image) begin
            term_d = T_BERR; // [R8]
         end else if (match) begin
            term_d = dly_term_q; // [R1]
         end else if (dly_busy_q || dly_done_q) begin
            term_d = T_RETRY; // [R7] [R4]
         end else if (lb_cmd.ent.write && lb_cmd.posted) begin
            if (lb_cmd.burst ? wf_free >= FREE_W'(BURST_BEATS) : wf_free != '0) begin
               term_d = T_NORMAL; // [R13]
               push_d = 1'b1;
            end else begin
               term_d = T_RETRY; // [R5] [R6]
            end
         end else begin
            term_d = T_RETRY; // [R1]
            latch_d = 1'b1;
         end
      end
   end

   // local termination outputs
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         term_q <= T_NONE;
         lb_done <= 1'b0;
         lb_pins <= PINS_IDLE;
         lb_rdata <= '0;
         wf_push <= 1'b0;
         wf_data <= '0;
      end else begin
         term_q <= term_d;
         lb_done <= lb_req;
         lb_pins <= lb_req ? pins_for(mode_q, term_d) : PINS_IDLE;
         lb_rdata <= (lb_req && match) ? dly_rdata_q : '0;
         wf_push <= push_d;
         if (push_d) wf_data <= lb_cmd.ent;
      end
   end

   // pci outcome
   always_comb begin
      unique case (max_retry_select_q)
         RTRY_SEL_128: lim = RTRY_LIM_128; // [R23]
         RTRY_SEL_256: lim = RTRY_LIM_256;
         RTRY_SEL_384: lim = RTRY_LIM_384;
         RTRY_SEL_NONE: lim = '0;
      endcase
   end
   assign lim_hit = pm_result == RES_RETRY && max_retry_select_q != RTRY_SEL_NONE
                    && rcnt_q == lim - 9'h001; // [R21]
   assign fin = pst_q == P_BUSY && pm_done
                && (pm_result inside {RES_DONE, RES_MABORT, RES_TABORT} || lim_hit);
   assign failed = pm_result != RES_DONE;
   assign fin_dly = fin && !src_q;
   assign log_fire = fin && src_q && failed && log_en_q && !log_status_q; // [R15] [R22]

   always_comb begin
      fin_term = T_NORMAL;
      rdata_d = ALL_ONES; // [R2] [R3]
      if (lim_hit) fin_term = T_BERR; // [R22]
      else if (pm_result == RES_MABORT) fin_term = ma_normal_q ? T_NORMAL : T_BERR; // [R2]
      else if (pm_result == RES_TABORT)
         fin_term = (!ma_normal_q || target_abort_bus_error_enable_q) ? T_BERR : T_NORMAL; // [R3]
      else rdata_d = pm_rdata;
   end

   // pci master sequencing
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pst_q <= P_IDLE;
         src_q <= 1'b0;
         rcnt_q <= '0;
         pm_req <= 1'b0;
         pm_cyc <= '0;
         pw_pop <= 1'b0;
         rf_flush <= 1'b0;
      end else begin
         pw_pop <= 1'b0;
         rf_flush <= 1'b0;
         unique case (pst_q)
            P_IDLE: begin
               rcnt_q <= '0;
               if (!suspend && pw_valid) begin // [R16] [R18]
                  pst_q <= P_BUSY;
                  src_q <= 1'b1;
                  pm_req <= 1'b1;
                  pm_cyc <= pw_entry;
               end else if (!suspend && dly_busy_q) begin
                  pst_q <= P_BUSY;
                  src_q <= 1'b0;
                  pm_req <= 1'b1;
                  pm_cyc <= dly_req_q;
               end
            end
            P_BUSY: begin
               if (fin) begin
                  pst_q <= P_IDLE;
                  pm_req <= 1'b0;
                  pw_pop <= src_q; // [R13] [R19]
                  rf_flush <= !src_q && !pm_cyc.write && failed; // [R14]
               end else if (pm_done && pm_result == RES_RETRY) begin
                  rcnt_q <= rcnt_q + 9'h001; // [R21]
               end
            end
         endcase
      end
   end

   // delayed transfer tracking
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dly_busy_q <= 1'b0;
         dly_done_q <= 1'b0;
         dly_req_q <= '0;
         dly_term_q <= T_NONE;
         dly_rdata_q <= '0;
      end else begin
         if (latch_d) begin
            dly_busy_q <= 1'b1; // [R1]
            dly_req_q <= lb_cmd.ent;
         end else if (fin_dly) begin
            dly_busy_q <= 1'b0;
            dly_done_q <= 1'b1; // [R4]
            dly_term_q <= fin_term;
            dly_rdata_q <= rdata_d;
         end else if (lb_req && match && term_d == dly_term_q && !suspend) begin
            dly_done_q <= 1'b0;
         end
      end
   end

   // software control registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ma_normal_q <= RST_MA_NORMAL;
         mode_q <= M_ASYNC;
         target_abort_bus_error_enable_q <= RST_TARGET_ABORT_BUS_ERROR_ENABLE;
         max_retry_select_q <= RST_MAX_RETRY_SELECT;
         log_en_q <= 1'b0;
         unlock_q <= RST_UNLOCK;
         irq_en_q <= 1'b0;
         irq_dir_q <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == REG_MISC1) begin
            ma_normal_q <= reg_wdata[B_MA_NORMAL];
            mode_q <= lstel_mode_e'(reg_wdata[B_MODE+:2]);
         end
         if (reg_addr == REG_MISC2) begin
            target_abort_bus_error_enable_q <= reg_wdata[B_TARGET_ABORT_BUS_ERROR_ENABLE];
            max_retry_select_q <= reg_wdata[B_MAX_RETRY_SELECT+:2];
         end
         if (reg_addr == REG_ELOG_CTL) begin
            log_en_q <= reg_wdata[B_LOG_EN];
            unlock_q <= reg_wdata[B_UNLOCK];
         end
         if (reg_addr == REG_IRQ_CTL) begin
            irq_en_q <= reg_wdata[B_IRQ_EN];
            irq_dir_q <= reg_wdata[B_IRQ_DIR];
         end
      end
   end

   // error log capture; while status is set, a same-cycle clear wins and the new error is lost
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         log_status_q <= 1'b0;
         log_cmd_q <= '0;
         log_be_q <= '0;
         log_addr_q <= '0;
         log_data_q <= '0;
      end else if (log_fire) begin
         log_status_q <= 1'b1; // [R15]
         log_cmd_q <= pm_cyc.cmd;
         log_be_q <= pm_cyc.be;
         log_addr_q <= pm_cyc.addr;
         log_data_q <= pm_cyc.data;
      end else if (reg_wr && reg_addr == REG_ELOG_CTL && reg_wdata[B_LOG_STATUS]) begin
         log_status_q <= 1'b0; // [R18]
      end
   end

   // interrupt outputs
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq_local <= 1'b0;
         irq_pci <= 1'b0;
      end else begin
         irq_local <= log_status_q && irq_en_q && !irq_dir_q; // [R20]
         irq_pci <= log_status_q && irq_en_q && irq_dir_q;
      end
   end

   // register read port, data in the cycle after the strobe
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
         if (reg_rd) begin
            unique case (reg_addr)
               REG_MISC1: reg_rdata <= {29'h0, mode_q, ma_normal_q};
               REG_MISC2: reg_rdata <= {29'h0, max_retry_select_q, target_abort_bus_error_enable_q};
               REG_ELOG_CTL: reg_rdata <= {16'h0, log_cmd_q, log_be_q, 5'h0,
                                           unlock_q, log_status_q, log_en_q};
               REG_ELOG_ADDR: reg_rdata <= log_addr_q;
               REG_ELOG_DATA: reg_rdata <= log_data_q;
               REG_IRQ_CTL: reg_rdata <= {30'h0, irq_dir_q, irq_en_q};
               REG_STATUS: reg_rdata <= {28'h0, pst_q == P_BUSY, suspend,
                                         dly_done_q, dly_busy_q};
               default: reg_rdata <= '0;
            endcase
         end
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence s_log_then_en;
      log_fire ##1 (irq_en_q && !irq_dir_q);
   endsequence

   a_dly_pend_retry: assert property ( // [R1]
      lb_req && dly_busy_q && !ongoing && !(lb_cmd.burst && lb_cmd.io_image)
      |=> term_q == T_RETRY && lb_done)
      else $error("access not retried while delayed transfer pending");
   a_ma_berr: assert property ( // [R2]
      fin_dly && pm_result == RES_MABORT && !ma_normal_q |=> dly_term_q == T_BERR)
      else $error("master-abort did not give bus error");
   a_ma_ones: assert property ( // [R2]
      fin_dly && pm_result == RES_MABORT && ma_normal_q
      |=> dly_term_q == T_NORMAL && dly_rdata_q == ALL_ONES)
      else $error("master-abort normal ending wrong");
   a_ta_map: assert property ( // [R3]
      fin_dly && pm_result == RES_TABORT |=> dly_term_q ==
      ((!$past(ma_normal_q) || $past(target_abort_bus_error_enable_q)) ? T_BERR : T_NORMAL))
      else $error("target-abort translation wrong");
   a_nofit_retry: assert property ( // [R5]
      lb_req && lb_cmd.ent.write && lb_cmd.posted && !lb_cmd.burst && wf_free == '0
      && !dly_busy_q && !dly_done_q && !suspend |=> term_q == T_RETRY && !wf_push)
      else $error("posted write without room not retried");
   a_push_normal: assert property ( // [R13]
      wf_push |-> term_q == T_NORMAL)
      else $error("accepted write not ended normally");
   a_io_burst_berr: assert property ( // [R8]
      lb_req && lb_cmd.burst && lb_cmd.io_image && !ongoing && !suspend
      |=> term_q == T_BERR)
      else $error("i/o burst not ended with bus error");
   a_burst_retry_pins: assert property ( // [R10]
      lb_req && term_d == T_RETRY && mode_q == M_BURST_RETRY ##1 !lb_req
      |-> lb_pins.oe_n == 4'h7 && lb_pins.o[3] == 1'b0 ##1 lb_pins == PINS_IDLE)
      else $error("burst-retry mode retry pins wrong");
   a_two_line_berr: assert property ( // [R11]
      lb_req && term_d == T_BERR && mode_q == M_TWO_LINE
      |=> lb_pins.oe_n == 4'h9 && lb_pins.o == 4'hb)
      else $error("two-line bus error pins wrong");
   a_abort_flush: assert property ( // [R14]
      fin && failed |=> rf_flush == (!$past(src_q) && !pm_cyc.write))
      else $error("read fifo flush wrong on abort");
   a_log_freeze: assert property ( // [R18]
      log_status_q ##1 log_status_q |-> $stable(log_addr_q) && $stable(log_data_q))
      else $error("error log changed while frozen");
   a_suspend_hold: assert property ( // [R16]
      suspend && pst_q == P_IDLE |=> !pm_req)
      else $error("pci master started while suspended");
   a_limit_berr: assert property ( // [R22]
      fin_dly && lim_hit |=> dly_term_q == T_BERR ##0 pst_q == P_IDLE)
      else $error("retry limit did not give bus error");
   a_irq_gate: assert property ( // [R20]
      s_log_then_en |=> irq_local && !irq_pci)
      else $error("logged error did not raise local interrupt");
endmodule // lstel_top
`default_nettype wire

/* lstel_pkg.sv */
/*
 * package for the local slave termination and error-log block:
 * register offsets, field positions, reset values, encodings, carriers.
 * assumes one clock domain and a plain register port with 8-bit byte addresses.
 */
`default_nettype none
package lstel_pkg;
   // register byte offsets
   localparam logic [7:0] REG_MISC1 = 8'h00;
   localparam logic [7:0] REG_MISC2 = 8'h04;
   localparam logic [7:0] REG_ELOG_CTL = 8'h08;
   localparam logic [7:0] REG_ELOG_ADDR = 8'h0c;
   localparam logic [7:0] REG_ELOG_DATA = 8'h10;
   localparam logic [7:0] REG_IRQ_CTL = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   // field positions
   localparam int B_MA_NORMAL = 0;
   localparam int B_MODE = 1;
   localparam int B_TARGET_ABORT_BUS_ERROR_ENABLE = 0;
   localparam int B_MAX_RETRY_SELECT = 1;
   localparam int B_LOG_EN = 0;
   localparam int B_LOG_STATUS = 1;
   localparam int B_UNLOCK = 2;
   localparam int B_LOG_BE = 8;
   localparam int B_LOG_CMD = 12;
   localparam int B_IRQ_EN = 0;
   localparam int B_IRQ_DIR = 1;
   // reset values
   localparam logic RST_MA_NORMAL = 1'b0;
   localparam logic RST_TARGET_ABORT_BUS_ERROR_ENABLE = 1'b0;
   localparam logic [1:0] RST_MAX_RETRY_SELECT = 2'h0;
   localparam logic RST_UNLOCK = 1'b0;
   // retry limits selected by max_retry_select
   localparam logic [1:0] RTRY_SEL_128 = 2'h0;
   localparam logic [1:0] RTRY_SEL_256 = 2'h1;
   localparam logic [1:0] RTRY_SEL_384 = 2'h2;
   localparam logic [1:0] RTRY_SEL_NONE = 2'h3;
   localparam logic [8:0] RTRY_LIM_128 = 9'h080;
   localparam logic [8:0] RTRY_LIM_256 = 9'h100;
   localparam logic [8:0] RTRY_LIM_384 = 9'h180;
   // termination line masks, lines are active low
   localparam logic [3:0] L_ACK0 = 4'h1;
   localparam logic [3:0] L_ACK1 = 4'h2;
   localparam logic [3:0] L_ERR = 4'h4;
   localparam logic [3:0] L_HALT = 4'h8;
   localparam logic [31:0] ALL_ONES = 32'hffff_ffff;

   typedef enum logic [1:0] {
      M_ASYNC = 2'h0,
      M_BURST_RETRY = 2'h1,
      M_TWO_LINE = 2'h2
   } lstel_mode_e;

   typedef enum logic [1:0] {
      T_NONE = 2'h0,
      T_NORMAL = 2'h1,
      T_BERR = 2'h3,
      T_RETRY = 2'h2
   } lstel_term_e;

   typedef enum logic [2:0] {
      RES_DONE = 3'h0,
      RES_MABORT = 3'h1,
      RES_TABORT = 3'h2,
      RES_RETRY = 3'h3,
      RES_DISC = 3'h4
   } lstel_res_e;

   typedef enum logic [0:0] {
      P_IDLE = 1'b0,
      P_BUSY = 1'b1
   } lstel_pst_e;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0] cmd;
      logic [3:0] be;
      logic write;
   } lstel_ent_s;

   typedef struct packed {
      lstel_ent_s ent;
      logic posted;
      logic burst;
      logic first;
      logic io_image;
   } lstel_lreq_s;

   // bit 0 async_ack_low, 1 transfer_ack_line, 2 transfer_error_line, 3 halt_retry_line
   typedef struct packed {
      logic [3:0] o;
      logic [3:0] oe_n;
   } lstel_pins_s;

   localparam lstel_pins_s PINS_IDLE = '{o: 4'hf, oe_n: 4'hf};
endpackage
`default_nettype wire

/* lstel_pci_model.sv */
/*
 * pci master stand-in: answers each attempt of pm_req after a short delay.
 * assumes the bench chooses the final result, the retry count and retry kind.
 */
`default_nettype none
module lstel_pci_model
   import lstel_pkg::*;
#(
   parameter logic [31:0] RD_WORD = 32'h5a5a_1234
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic pm_req,
   input wire lstel_res_e res_sel,
   input wire lstel_res_e rty_kind,
   input wire logic [15:0] n_retry,
   output logic pm_done,
   output lstel_res_e pm_result,
   output logic [31:0] pm_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_q;
   logic [1:0] dly_q;
   logic fin_q;
   // read data toggles outside a final answer so stale data changes every cycle
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pm_done <= 1'b0;
         pm_result <= RES_DISC;
         pm_rdata <= 32'h0;
         cnt_q <= 16'h0;
         dly_q <= 2'h0;
         fin_q <= 1'b0;
      end else begin
         pm_done <= 1'b0;
         pm_result <= RES_DISC;
         pm_rdata <= ~pm_rdata;
         if (!pm_req) begin
            cnt_q <= 16'h0;
            dly_q <= 2'h0;
            fin_q <= 1'b0;
         end else if (!fin_q && !pm_done) begin
            if (dly_q != 2'h2) begin
               dly_q <= dly_q + 2'h1;
            end else begin
               dly_q <= 2'h0;
               pm_done <= 1'b1;
               if (cnt_q < n_retry) begin
                  pm_result <= rty_kind;
                  cnt_q <= cnt_q + 16'h1;
               end else begin
                  pm_result <= res_sel;
                  pm_rdata <= RD_WORD;
                  fin_q <= 1'b1;
               end
            end
         end
      end
   end
endmodule // lstel_pci_model
`default_nettype wire

/* lstel_top_tb.sv */
/*
 * self-checking bench for the termination and error-log block.
 * assumes the pci master model beside it; the bench plays the local master,
 * the software and the write fifo head.
 */
`default_nettype none
module lstel_top_tb;
   import lstel_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] RD = 32'h5a5a_1234;
   localparam int BB = 4;
   typedef struct packed {
      lstel_mode_e m;
      logic ma;
      logic ta;
      lstel_res_e r;
      logic [3:0] lv;
      logic [3:0] rl;
      logic [31:0] d;
   } lstel_row_s;
   lstel_row_s rows [7] = '{
      '{M_ASYNC, 1'b0, 1'b0, RES_DONE, 4'hc, 4'h0, RD},
      '{M_ASYNC, 1'b0, 1'b0, RES_MABORT, 4'h8, 4'h0, 32'h0},
      '{M_ASYNC, 1'b1, 1'b0, RES_MABORT, 4'hc, 4'h0, ALL_ONES},
      '{M_BURST_RETRY, 1'b0, 1'b1, RES_TABORT, 4'hb, 4'h7, 32'h0},
      '{M_BURST_RETRY, 1'b1, 1'b0, RES_TABORT, 4'hd, 4'h7, ALL_ONES},
      '{M_TWO_LINE, 1'b1, 1'b1, RES_TABORT, 4'hb, 4'h9, 32'h0},
      '{M_TWO_LINE, 1'b0, 1'b0, RES_DONE, 4'hd, 4'h9, RD}};
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] ra = 8'h0;
   logic [31:0] rw = 32'h0;
   logic [31:0] rdat;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic lb_req = 1'b0;
   lstel_lreq_s lb_cmd = '0;
   logic lb_done;
   logic [31:0] lb_rdata;
   lstel_pins_s pins;
   logic [7:0] wf_free = 8'h0;
   logic wf_push;
   logic pw_valid = 1'b0;
   lstel_ent_s pw_entry = '0;
   logic pw_pop;
   logic rf_flush;
   lstel_ent_s wfd;
   lstel_ent_s pmc;
   logic pm_req;
   logic pm_done;
   lstel_res_e pm_result;
   lstel_res_e res_sel = RES_DONE;
   lstel_res_e rty = RES_DISC;
   logic [15:0] nrt = 16'h0;
   logic [31:0] pm_rdata;
   logic irq_l;
   logic irq_p;
   int err_count = 0;
   int n_checks = 0;
   int nfl = 0;
   int npush = 0;
   int ndone = 0;
   // floated lines read high through the board pull-ups
   wire logic [3:0] lvl = pins.o | pins.oe_n;

   lstel_top #(.BURST_BEATS(BB), .FREE_W(8)) dut (.mclk(mclk), .rstn(rstn), .reg_addr(ra),
      .reg_wdata(rw), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat), .lb_req(lb_req),
      .lb_cmd(lb_cmd), .lb_done(lb_done), .lb_rdata(lb_rdata), .lb_pins(pins),
      .wf_free(wf_free), .wf_push(wf_push), .wf_data(wfd), .pw_valid(pw_valid),
      .pw_entry(pw_entry), .pw_pop(pw_pop), .rf_flush(rf_flush), .pm_req(pm_req),
      .pm_cyc(pmc), .pm_done(pm_done), .pm_result(pm_result), .pm_rdata(pm_rdata),
      .irq_local(irq_l), .irq_pci(irq_p));
   lstel_pci_model #(.RD_WORD(RD)) pci (.mclk(mclk), .rstn(rstn), .pm_req(pm_req),
      .res_sel(res_sel), .rty_kind(rty), .n_retry(nrt), .pm_done(pm_done),
      .pm_result(pm_result), .pm_rdata(pm_rdata));

   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      if (rf_flush === 1'b1) nfl++;
      if (wf_push === 1'b1) npush++;
      if (pm_done === 1'b1) ndone++;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cyc;
      @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      ra <= a;
      rw <= d;
      wr_s <= 1'b1;
      @(posedge mclk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      ra <= a;
      rd_s <= 1'b1;
      @(posedge mclk);
      rd_s <= 1'b0;
      #1 d = rdat;
   endtask
   task automatic acc(input lstel_lreq_s c);
      @(posedge mclk);
      lb_req <= 1'b1;
      lb_cmd <= c;
      @(posedge mclk);
      lb_req <= 1'b0;
      #1;
   endtask
   function automatic lstel_lreq_s mk(input logic [31:0] a, input logic w, p, b, f, io);
      mk = '{ent: '{addr: a, data: ~a, cmd: 4'h6, be: 4'hf, write: w}, posted: p,
         burst: b, first: f, io_image: io};
   endfunction
   task automatic wpm;
      int i;
      for (i = 0; i < 5000 && pm_req !== 1'b1; i++) cyc;
      chk(i < 5000, 1);
      for (i = 0; i < 5000 && pm_req !== 1'b0; i++) cyc;
      chk(i < 5000, 1);
   endtask
   task automatic post(input logic [31:0] a, input lstel_res_e r);
      int i;
      lstel_lreq_s t;
      t = mk(a, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
      @(posedge mclk);
      res_sel <= r;
      nrt <= 16'h0;
      pw_entry <= t.ent;
      pw_valid <= 1'b1;
      for (i = 0; i < 100 && pw_pop !== 1'b1; i++) cyc;
      pw_valid <= 1'b0;
      chk(i < 100, 1);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #400000;
      err_count++;
      complete_run;
   end

   initial begin
      int k;
      int f;
      logic [31:0] v;
      lstel_row_s r;
      lstel_lreq_s c;
      repeat (16) @(posedge mclk);
      chk(lvl, 4'hf);
      rstn <= 1'b1;
      rd(REG_MISC1, v);
      chk(v, 32'h0);
      rd(REG_MISC2, v);
      chk(v, 32'h0);
      rd(8'h1c, v);
      chk(v, 32'h0);
      for (k = 0; k < 7; k++) begin
         r = rows[k];
         wr(REG_MISC1, {29'h0, r.m, r.ma});
         wr(REG_MISC2, {31'h0, r.ta});
         res_sel <= r.r;
         nrt <= 16'h2;
         rty <= RES_DISC;
         f = nfl;
         c = mk(32'h100 + 32'(k * 16), 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
         acc(c);
         chk(lvl, r.rl);
         acc(mk(32'h8000, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0));
         chk(lvl, r.rl);
         chk(pmc.addr, c.ent.addr);
         wpm;
         acc(c);
         chk(lvl, r.lv);
         chk(lb_done, 1'b1);
         if (r.d != 32'h0) chk(lb_rdata, r.d);
         chk(nfl - f, r.r != RES_DONE);
      end
      wr(REG_MISC1, 32'h0);
      c = mk(32'h2000, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
      acc(c);
      chk(lvl, 4'h0);
      wf_free <= 8'h1;
      acc(c);
      chk(lvl, 4'hc);
      chk(wfd.addr, 32'h2000);
      wf_free <= 8'(BB - 1);
      c = mk(32'h3000, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
      acc(c);
      chk(lvl, 4'h0);
      wf_free <= 8'(BB);
      acc(c);
      chk(lvl, 4'hc);
      wf_free <= 8'h0;
      for (k = 1; k < BB; k++) begin
         acc(mk(32'h3000 + 32'(k * 4), 1'b1, 1'b1, 1'b1, 1'b0, 1'b0));
         chk(lvl, 4'hc);
      end
      cyc;
      chk(npush, BB + 1);
      acc(mk(32'h4000, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1));
      chk(lvl, 4'h8);
      wr(REG_ELOG_CTL, 32'h1);
      wr(REG_IRQ_CTL, 32'h1);
      post(32'h4440, RES_MABORT);
      repeat (3) cyc;
      rd(REG_ELOG_ADDR, v);
      chk(v, 32'h4440);
      rd(REG_ELOG_DATA, v);
      chk(v, ~32'h4440);
      rd(REG_ELOG_CTL, v);
      chk(v, 32'h6f03);
      chk({irq_l, irq_p}, 2'h2);
      acc(mk(32'h9000, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0));
      chk(lvl, 4'h0);
      wr(REG_ELOG_CTL, 32'h7);
      repeat (3) cyc;
      chk({irq_l, irq_p}, 2'h0);
      post(32'h5550, RES_TABORT);
      post(32'h6660, RES_MABORT);
      rd(REG_ELOG_ADDR, v);
      chk(v, 32'h5550);
      wr(REG_IRQ_CTL, 32'h3);
      repeat (3) cyc;
      chk({irq_l, irq_p}, 2'h1);
      wr(REG_ELOG_CTL, 32'h6);
      post(32'h7770, RES_MABORT);
      rd(REG_ELOG_CTL, v);
      chk(v[1], 1'b0);
      wr(REG_ELOG_CTL, 32'h0);
      for (k = 0; k < 4; k++) begin
         wr(REG_MISC2, {29'h0, 2'(k), 1'b0});
         res_sel <= RES_DONE;
         rty <= RES_RETRY;
         nrt <= (k == 3) ? 16'h0190 : 16'hffff;
         ndone = 0;
         c = mk(32'ha000 + 32'(k * 16), 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
         acc(c);
         wpm;
         chk(ndone, (k == 3) ? 32'h191 : 32'h80 * (k + 1));
         acc(c);
         chk(lvl, (k == 3) ? 4'hc : 4'h8);
      end
      rstn <= 1'b0;
      repeat (2) cyc;
      chk({pm_req, irq_l, irq_p, lvl}, 7'h0f);
      rstn <= 1'b1;
      rd(REG_ELOG_CTL, v);
      chk(v, 32'h0);
      complete_run;
   end
endmodule // lstel_top_tb
`default_nettype wire
